//--- common/analog_init_if.sv
`timescale 1ns/1ps
`default_nettype none
`include "analog_init_regs.svh"
interface analog_init_if;
  logic [`INIT_DATA_W-1:0] init_data;
  logic cfg_store_load_strobe;
  logic sequencer_ram_load_strobe;
  logic eval_ram_load_strobe;
  logic thresh_ram_load_strobe;
  logic cfg_store_second_pass_strobe;
  logic init_complete;
  // controller end drives the load bus
  modport ctrl (
    output init_data, cfg_store_load_strobe, sequencer_ram_load_strobe,
    output eval_ram_load_strobe, thresh_ram_load_strobe, cfg_store_second_pass_strobe,
    output init_complete
  );
  // analog end receives it
  modport dev (
    input init_data, cfg_store_load_strobe, sequencer_ram_load_strobe,
    input eval_ram_load_strobe, thresh_ram_load_strobe, cfg_store_second_pass_strobe,
    input init_complete
  );
endinterface : analog_init_if
`default_nettype wire

//--- common/analog_init_pkg.sv
package analog_init_pkg;
  // target store for one initialization write
  typedef enum logic [2:0] {
    TGT_CFG = 3'h0,
    TGT_SEQ = 3'h1,
    TGT_EVAL = 3'h2,
    TGT_THR = 3'h3,
    TGT_CFG2 = 3'h4
  } load_target_e;
  // sequencer slot states
  typedef enum logic [4:0] {
    SQ_IDLE = 5'b00001,
    SQ_LATCH = 5'b00010,
    SQ_CONV = 5'b00100,
    SQ_WAIT = 5'b01000,
    SQ_DONE = 5'b10000
  } slot_state_e;
endpackage : analog_init_pkg

//--- common/analog_init_regs.svh
`ifndef ANALOG_INIT_REGS_SVH
`define ANALOG_INIT_REGS_SVH
// initialization data bus width
`define INIT_DATA_W 9
// channel selector width
`define CHSEL_W 5
// converter result width
`define RESULT_W 12
// saturation code: full scale result
`define RESULT_FULL 12'hfff
// store depths
`define CFG_DEPTH 32
`define SEQ_DEPTH 64
`define EVAL_DEPTH 64
`define THR_DEPTH 64
// address widths of the stores
`define CFG_AW 5
`define RAM_AW 6
// wait states inserted per slot for the engines
`define SLOT_WAIT_CYCLES 4'h3
// converter latency after channel capture
`define CONV_CYCLES 4'h4
// controller software register addresses
`define CTL_ADDR_CTRL 4'h0
`define CTL_ADDR_STATUS 4'h1
`define CTL_ADDR_DATA 4'h2
`define CTL_ADDR_IRQ_STATUS 4'h3
`define CTL_ADDR_IRQ_CLEAR 4'h4
`define CTL_ADDR_IRQ_ENABLE 4'h5
// control register fields
`define CTRL_TARGET_LSB 0
`define CTRL_START_BIT 4
`define CTRL_FINISH_BIT 5
// irq bits
`define IRQ_WRITE_BIT 0
`define IRQ_DONE_BIT 1
`endif

//--- testbench/analog_init_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "analog_init_regs.svh"
module analog_init_sva (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // load bus
  input wire logic cfg_store_load_strobe,
  input wire logic sequencer_ram_load_strobe,
  input wire logic eval_ram_load_strobe,
  input wire logic thresh_ram_load_strobe,
  input wire logic cfg_store_second_pass_strobe,
  input wire logic init_complete,
  // converter and status
  input wire logic [`RESULT_W-1:0] conv_result,
  input wire logic conv_result_valid,
  input wire logic slot_complete,
  input wire logic slot_wait_inserted,
  input wire logic channel_saturated,
  input wire logic channel_select_captured
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // all five strobes gathered for the one-hot test
  logic [4:0] stb;
  assign stb = {cfg_store_second_pass_strobe, thresh_ram_load_strobe, eval_ram_load_strobe,
    sequencer_ram_load_strobe, cfg_store_load_strobe};
  // an aborted slot (load restarted) ends a step early
  sequence s_conv;
    ##[3:5] (conv_result_valid || !init_complete);
  endsequence
  sequence s_wait;
    slot_wait_inserted [*3] ##1 !slot_wait_inserted;
  endsequence
  property p_one_strobe; $onehot0(stb); endproperty
  a_one_strobe: assert property (p_one_strobe) else $error("two strobes");
  property p_no_load_done; |stb |-> !init_complete; endproperty
  a_no_load_done: assert property (p_no_load_done) else $error("load after done");
  property p_conv; channel_select_captured |-> s_conv; endproperty
  a_conv: assert property (p_conv) else $error("no valid after capture");
  property p_wait; $rose(slot_wait_inserted) |-> s_wait; endproperty
  a_wait: assert property (p_wait) else $error("wait length");
  property p_done; $fell(slot_wait_inserted) |-> ##[0:1] slot_complete; endproperty
  a_done: assert property (p_done) else $error("no done after wait");
  property p_period; slot_complete |=> !slot_complete [*8]; endproperty
  a_period: assert property (p_period) else $error("done too soon");
  property p_sat_set;
    $rose(channel_saturated) |-> conv_result_valid && $past(conv_result) == `RESULT_FULL;
  endproperty
  a_sat_set: assert property (p_sat_set) else $error("saturation cause");
  property p_sat_clr;
    $fell(channel_saturated) |-> ##[0:1] (channel_select_captured || !init_complete);
  endproperty
  a_sat_clr: assert property (p_sat_clr) else $error("saturation dropped early");
  // checked while reset is low, so it must not be disabled by it
  property p_reset;
    disable iff (1'b0) !nrst |-> !(conv_result_valid || slot_complete || channel_saturated);
  endproperty
  a_reset: assert property (p_reset) else $error("status high in reset");
endmodule : analog_init_sva
`default_nettype wire

//--- testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "analog_init_regs.svh"
module tb;
  logic clk_sys = 1'b0;
  logic nrst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic irq;
  logic [`RESULT_W-1:0] conv_result = 12'h000;
  logic [`RAM_AW-1:0] rd_addr = 6'h00;
  logic [`INIT_DATA_W-1:0] seq_word, eval_word, thr_word, cfg_word;
  logic valid, done, wt, sat, capt;
  logic [31:0] v;
  logic q;
  int mismatches = 0;
  int total_checks = 0;
  int ns [5];
  int ne [4];
  analog_init_if bus ();
  init_load_ctrl i_init_load_ctrl (.clk_sys(clk_sys), .nrst(nrst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .bus(bus));
  analog_init_port i_analog_init_port (.clk_sys(clk_sys), .nrst(nrst), .bus(bus),
    .conv_result(conv_result), .conv_channel_select(), .conv_result_valid(valid),
    .slot_complete(done), .slot_wait_inserted(wt), .channel_saturated(sat),
    .channel_select_captured(capt), .rd_addr(rd_addr), .seq_word(seq_word),
    .eval_word(eval_word), .thr_word(thr_word), .cfg_word(cfg_word));
  analog_init_sva i_analog_init_sva (.clk_sys(clk_sys), .nrst(nrst),
    .cfg_store_load_strobe(bus.cfg_store_load_strobe),
    .sequencer_ram_load_strobe(bus.sequencer_ram_load_strobe),
    .eval_ram_load_strobe(bus.eval_ram_load_strobe),
    .thresh_ram_load_strobe(bus.thresh_ram_load_strobe),
    .cfg_store_second_pass_strobe(bus.cfg_store_second_pass_strobe),
    .init_complete(bus.init_complete), .conv_result(conv_result), .conv_result_valid(valid),
    .slot_complete(done), .slot_wait_inserted(wt), .channel_saturated(sat),
    .channel_select_captured(capt));
  initial begin
    forever #50 clk_sys = ~clk_sys;
  end
  // counts strobes on the wire and status events
  always @(posedge clk_sys) begin
    ns[0] += bus.cfg_store_load_strobe;
    ns[1] += bus.sequencer_ram_load_strobe;
    ns[2] += bus.eval_ram_load_strobe;
    ns[3] += bus.thresh_ram_load_strobe;
    ns[4] += bus.cfg_store_second_pass_strobe;
    ne[0] += valid;
    ne[1] += done;
    ne[2] += capt;
    ne[3] += wt;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // strobe is left high so writes can follow with no gap
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys);
  endtask : wr_reg
  // second edge lets the strobe counter settle before any check
  task automatic idle;
    wr <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask : idle
  task automatic rd_reg(input logic [3:0] a);
    addr <= a;
    rd <= 1'b1;
    wr <= 1'b0;
    @(posedge clk_sys);
    rd <= 1'b0;
    @(negedge clk_sys);
    v = rdata;
    q = irq;
    @(posedge clk_sys);
  endtask : rd_reg
  task automatic rd_st(input logic [5:0] a, input logic [8:0] c, input logic [8:0] s);
    rd_addr <= a;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    chk("cfg_word", c, cfg_word);
    chk("seq_word", s, seq_word);
    @(posedge clk_sys);
  endtask : rd_st
  task automatic results;
    if (mismatches == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : results
  initial begin
    repeat (4000) @(posedge clk_sys);
    mismatches++;
    results();
  end
  initial begin
    nrst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    foreach (ns[i]) rd_reg(4'(i == 2 ? 15 : i));
    chk("unmapped", 32'h0, v);
    wr_reg(4'h5, 32'h3);
    wr_reg(4'h0, 32'h10);
    wr_reg(4'h2, 32'h1a5);
    wr_reg(4'h2, 32'h05a);
    for (int t = 1; t < 4; t++) begin
      wr_reg(4'h0, t);
      wr_reg(4'h2, 32'h100 + t);
      wr_reg(4'h2, 32'h110 + t);
    end
    // out-of-range target is ignored, so the word goes to the threshold RAM
    wr_reg(4'h0, 32'h5);
    wr_reg(4'h2, 32'h0ff);
    idle();
    chk("cfg_loads", 2, ns[0]);
    chk("seq_loads", 2, ns[1]);
    chk("eval_loads", 2, ns[2]);
    chk("thr_loads", 3, ns[3]);
    rd_reg(4'h3);
    chk("irq_status", 32'h1, v);
    chk("irq", 1, q);
    wr_reg(4'h4, 32'h1);
    rd_reg(4'h3);
    chk("irq_clear", 32'h0, {v[31:1], q});
    wr_reg(4'h0, 32'h20);
    rd_reg(4'h0);
    chk("ctrl", 32'h20, v);
    rd_reg(4'h1);
    chk("status", 32'h1, v);
    rd_reg(4'h3);
    chk("irq_finish", 32'h5, {v[30:0], q});
    wr_reg(4'h5, 32'h0);
    wr_reg(4'h2, 32'h1ff);
    rd_reg(4'h3);
    chk("irq_masked", 32'h0, q);
    chk("late_load", 9, ns[0] + ns[1] + ns[2] + ns[3] + ns[4]);
    rd_st(6'h00, 9'h1a5, 9'h101);
    chk("eval_word", 9'h102, eval_word);
    chk("thr_word", 9'h103, thr_word);
    rd_st(6'h01, 9'h05a, 9'h111);
    conv_result <= `RESULT_FULL;
    repeat (20) @(posedge clk_sys);
    // counters are cleared and read between edges to avoid racing the counter
    @(negedge clk_sys);
    foreach (ne[i]) ne[i] = 0;
    repeat (90) @(posedge clk_sys);
    @(negedge clk_sys);
    chk("valid_count", 10, ne[0]);
    chk("done_count", 10, ne[1]);
    chk("capture_count", 10, ne[2]);
    chk("wait_cycles", 30, ne[3]);
    // saturation is only sure to stand from the valid pulse to the next latch
    for (int i = 0; i < 20 && valid !== 1'b1; i++) @(negedge clk_sys);
    chk("saturated", 1, sat);
    @(posedge clk_sys);
    conv_result <= 12'h000;
    repeat (20) @(posedge clk_sys);
    chk("sat_cleared", 0, sat);
    for (int i = 0; i < 20 && done !== 1'b1; i++) @(negedge clk_sys);
    @(posedge clk_sys);
    wr_reg(4'h0, 32'h14);
    wr_reg(4'h2, 32'h0c3);
    wr_reg(4'h0, 32'h20);
    idle();
    chk("second_pass", 1, ns[4]);
    rd_st(6'h00, 9'h0c3, 9'h101);
    rd_st(6'h01, 9'h05a, 9'h111);
    results();
  end
endmodule : tb
`default_nettype wire

//--- verilog/analog_init_port.sv
// How it works
// - config strobe writes data into config store
// - sequencer strobe writes data into sequencer RAM
// - evaluation strobe writes data into evaluation RAM
// - threshold strobe writes data into threshold RAM
// - second-pass strobe rewrites config store, counter only
// - valid flag marks usable converter result
// - done pulses when a slot completes
// - wait high while engines need extra time
// - saturation raised on over-range sample
// - saturation holds until next slot starts
// - captured flag once channel select latched
// - signals active high unless named otherwise
// - reset asynchronous active low, clears all but the stores and readback words
// - controller drives one shared nine-bit data bus
// - controller signals initialization complete
//
// Our own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "analog_init_regs.svh"
module analog_init_port
  import analog_init_pkg::*;
#(
  parameter bit HAS_RTC = 1'b1 // second pass strobe present
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // load bus from the controller
  analog_init_if.dev bus,
  // converter side
  input wire logic [`RESULT_W-1:0] conv_result,
  output logic [`CHSEL_W-1:0] conv_channel_select,
  // status outputs
  output logic conv_result_valid,
  output logic slot_complete,
  output logic slot_wait_inserted,
  output logic channel_saturated,
  output logic channel_select_captured,
  // readback of stores for user logic
  input wire logic [`RAM_AW-1:0] rd_addr,
  output logic [`INIT_DATA_W-1:0] seq_word,
  output logic [`INIT_DATA_W-1:0] eval_word,
  output logic [`INIT_DATA_W-1:0] thr_word,
  output logic [`INIT_DATA_W-1:0] cfg_word
);
  // stores written during initialization
  logic [`INIT_DATA_W-1:0] cfg_mem [`CFG_DEPTH];
  logic [`CFG_AW-1:0] cfg_ptr_r; // config store write pointer
  logic [2:0] ram_we;
  logic cfg_we;
  logic [`RAM_AW-1:0] slot_r; // current sequencer slot
  logic [3:0] cnt_r; // cycle counter in a slot
  slot_state_e state_r;
  logic [`RESULT_W-1:0] result_r;

  // second pass strobe is ignored when the counter is absent
  assign cfg_we = bus.cfg_store_load_strobe
    || (HAS_RTC && bus.cfg_store_second_pass_strobe);
  assign ram_we = {bus.thresh_ram_load_strobe, bus.eval_ram_load_strobe,
                   bus.sequencer_ram_load_strobe};

  // config store write; the pointer returns to zero while init complete is high with no strobe
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cfg_ptr_r <= '0;
    end else if (cfg_we) begin
      cfg_mem[cfg_ptr_r] <= bus.init_data;
      cfg_ptr_r <= cfg_ptr_r + 1'b1;
    end else if (bus.init_complete) begin
      cfg_ptr_r <= '0;
    end
  end

  // three RAMs share one write pattern
  // each RAM lives in its own block so every array has a single driver
  for (genvar g = 0; g < 3; g++) begin : g_ram
    logic [`INIT_DATA_W-1:0] mem [`SEQ_DEPTH]; // RAM words
    logic [`RAM_AW-1:0] ptr_r; // write pointer
    always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
        ptr_r <= '0;
      end else if (ram_we[g]) begin
        mem[ptr_r] <= bus.init_data;
        ptr_r <= ptr_r + 1'b1;
      end else if (bus.init_complete) begin
        ptr_r <= '0;
      end
    end
  end

  // registered readback for user logic
  always_ff @(posedge clk_sys) begin
    seq_word <= g_ram[0].mem[rd_addr];
    eval_word <= g_ram[1].mem[rd_addr];
    thr_word <= g_ram[2].mem[rd_addr];
    cfg_word <= cfg_mem[rd_addr[`CFG_AW-1:0]];
  end

  // slot sequencer runs only after initialization completes
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_r <= SQ_IDLE;
      cnt_r <= 4'h0;
      slot_r <= '0;
    end else begin
      unique case (state_r)
        SQ_IDLE: if (bus.init_complete) state_r <= SQ_LATCH;
        SQ_LATCH: begin
          state_r <= SQ_CONV;
          cnt_r <= `CONV_CYCLES;
        end
        SQ_CONV: begin
          if (cnt_r == 4'h1) begin
            state_r <= SQ_WAIT;
            cnt_r <= `SLOT_WAIT_CYCLES;
          end else begin
            cnt_r <= cnt_r - 4'h1;
          end
        end
        SQ_WAIT: begin
          if (cnt_r == 4'h1) state_r <= SQ_DONE;
          else cnt_r <= cnt_r - 4'h1;
        end
        SQ_DONE: begin
          slot_r <= slot_r + 1'b1;
          state_r <= bus.init_complete ? SQ_LATCH : SQ_IDLE;
        end
        default: state_r <= SQ_IDLE;
      endcase
    end
  end

  // channel select taken from the sequencer word, latched once per slot
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      conv_channel_select <= '0;
      channel_select_captured <= 1'b0;
    end else if (state_r == SQ_LATCH) begin
      conv_channel_select <= g_ram[0].mem[slot_r][`CHSEL_W-1:0];
      channel_select_captured <= 1'b1;
    end else begin
      channel_select_captured <= 1'b0;
    end
  end

  // result capture and valid at end of conversion
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      result_r <= '0;
      conv_result_valid <= 1'b0;
    end else begin
      conv_result_valid <= (state_r == SQ_CONV) && (cnt_r == 4'h1);
      if (state_r == SQ_CONV && cnt_r == 4'h1) result_r <= conv_result;
    end
  end

  // wait and done indications
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      slot_wait_inserted <= 1'b0;
      slot_complete <= 1'b0;
    end else begin
      slot_wait_inserted <= (state_r == SQ_CONV && cnt_r == 4'h1)
        || (state_r == SQ_WAIT && cnt_r != 4'h1);
      slot_complete <= (state_r == SQ_WAIT) && (cnt_r == 4'h1);
    end
  end

  // saturation sticks for the slot, cleared as the next slot starts
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      channel_saturated <= 1'b0;
    end else if (state_r == SQ_CONV && cnt_r == 4'h1 && conv_result == `RESULT_FULL) begin
      channel_saturated <= 1'b1;
    end else if (state_r == SQ_LATCH) begin
      channel_saturated <= 1'b0;
    end
  end
endmodule : analog_init_port
`default_nettype wire

//--- verilog/init_load_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "analog_init_regs.svh"
module init_load_ctrl
  import analog_init_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // software register port
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  output logic irq,
  // load bus toward the analog end
  analog_init_if.ctrl bus
);
  logic [2:0] target_r; // store chosen by software
  logic [`INIT_DATA_W-1:0] data_r; // word to send
  logic [4:0] strobe_r; // one-hot strobes
  logic done_r; // init complete level
  logic [31:0] rdata_r;
  logic [1:0] irq_stat_r;
  logic [1:0] irq_en_r;
  logic write_ev;
  logic done_ev;

  // a data write launches one strobe, so at most one fires a cycle
  assign write_ev = wr && (addr == `CTL_ADDR_DATA) && !done_r;
  assign done_ev = wr && (addr == `CTL_ADDR_CTRL) && wdata[`CTRL_FINISH_BIT] && !done_r;

  // strobe and data leave together from flops
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      strobe_r <= 5'h00;
      data_r <= '0;
    end else if (write_ev) begin
      data_r <= wdata[`INIT_DATA_W-1:0];
      strobe_r <= 5'h01 << target_r;
    end else begin
      strobe_r <= 5'h00;
    end
  end

  // target selection and completion level
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      target_r <= 3'h0;
      done_r <= 1'b0;
    end else if (wr && addr == `CTL_ADDR_CTRL) begin
      if (wdata[`CTRL_TARGET_LSB +: 3] <= 3'h4)
        target_r <= wdata[`CTRL_TARGET_LSB +: 3];
      if (wdata[`CTRL_START_BIT])
        done_r <= 1'b0;
      else if (wdata[`CTRL_FINISH_BIT])
        done_r <= 1'b1;
    end
  end

  // sticky events; set wins over clear
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      irq_stat_r <= 2'h0;
      irq_en_r <= 2'h0;
    end else begin
      if (wr && addr == `CTL_ADDR_IRQ_ENABLE)
        irq_en_r <= wdata[1:0];
      irq_stat_r <= (irq_stat_r & ~((wr && addr == `CTL_ADDR_IRQ_CLEAR) ? wdata[1:0] : 2'h0))
        | {done_ev, write_ev};
    end
  end

  // read data in the cycle after the strobe
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rdata_r <= 32'h0;
    end else if (rd) begin
      unique case (addr)
        `CTL_ADDR_CTRL: rdata_r <= {26'h0, done_r, 2'h0, target_r};
        `CTL_ADDR_STATUS: rdata_r <= {26'h0, strobe_r, done_r};
        `CTL_ADDR_DATA: rdata_r <= {23'h0, data_r};
        `CTL_ADDR_IRQ_STATUS: rdata_r <= {30'h0, irq_stat_r};
        `CTL_ADDR_IRQ_ENABLE: rdata_r <= {30'h0, irq_en_r};
        default: rdata_r <= 32'h0;
      endcase
    end else begin
      rdata_r <= 32'h0;
    end
  end

  assign rdata = rdata_r;
  assign irq = |(irq_stat_r & irq_en_r);
  assign bus.init_data = data_r;
  assign bus.cfg_store_load_strobe = strobe_r[0];
  assign bus.sequencer_ram_load_strobe = strobe_r[1];
  assign bus.eval_ram_load_strobe = strobe_r[2];
  assign bus.thresh_ram_load_strobe = strobe_r[3];
  assign bus.cfg_store_second_pass_strobe = strobe_r[4];
  assign bus.init_complete = done_r;
endmodule : init_load_ctrl
`default_nettype wire
